// [rtl/hbf_pkg.sv]
package hbf_pkg;
   // register indices; byte address is four times the index
   localparam logic [1:0] CTRL_IDX  = 2'h0;
   localparam logic [1:0] FAULT_IDX = 2'h1;
   localparam int         ADDR_W    = 4;

   // control register fields
   localparam int CTRL_IN_A_BIT   = 0;
   localparam int CTRL_IN_B_BIT   = 1;
   localparam int CTRL_CODE_LSB   = 2;
   localparam int CODE_W          = 6;
   localparam logic [7:0] CTRL_RST = 8'h00;

   // fault register fields
   localparam int FLT_SUMMARY_BIT = 0;
   localparam int FLT_OC_BIT      = 1;
   localparam int FLT_UV_BIT      = 2;
   localparam int FLT_OT_BIT      = 3;
   localparam int FLT_SUST_BIT    = 4;
   localparam int FLT_CLEAR_BIT   = 7;
   localparam logic [7:0] FAULT_RST = 8'h00;

   // reserved voltage codes and the reference
   localparam logic [5:0] CODE_RSVD_MAX = 6'h05;
   localparam int         VREF_MV       = 1285;

   // timing at the 20 MHz system clock
   localparam int CLK_PERIOD_NS    = 50;
   localparam int ILIM_DEGLITCH_NS = 3000;
   localparam int ILIM_DEGLITCH_CYC =
      (ILIM_DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SUST_FAULT_MS    = 275;
   localparam int SUST_FAULT_CYC   = SUST_FAULT_MS * (1000000 / CLK_PERIOD_NS);
   localparam int RAMP_MS          = 12;
   localparam int DUTY_W           = 8;
   localparam int RAMP_STEP_CYC    =
      RAMP_MS * (1000000 / CLK_PERIOD_NS) / ((1 << DUTY_W) - 1);
   localparam int OC_DEGLITCH_CYC  = 20;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : hbf_pkg

// [rtl/hbf_pwm_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface hbf_pwm_if;
   logic                       run;
   logic                       limit;
   logic                       below;
   logic                       above;
   logic                       pwm_on;
   logic [hbf_pkg::DUTY_W-1:0] duty;
   modport ctl (output run, output limit, output below, output above,
                input pwm_on, input duty);
   modport pwm (input run, input limit, input below, input above,
                output pwm_on, output duty);
endinterface : hbf_pwm_if
`default_nettype wire

// [rtl/hbf_pwm.sv]
`timescale 1ns/1ps
`default_nettype none
module hbf_pwm #(
   parameter int RAMP_STEP_CYC = hbf_pkg::RAMP_STEP_CYC
) (
   input wire logic clock_i,   // system clock
   input wire logic sys_rst_i, // synchronous reset, active high
   hbf_pwm_if.pwm   pif        // regulation request and pwm result
);
   localparam int DW = hbf_pkg::DUTY_W;
   localparam logic [DW-1:0] DUTY_MAX = {DW{1'b1}};

   logic [DW-1:0] duty_ff;
   logic [DW-1:0] cnt_ff;
   logic [19:0]   step_ff;
   logic          pwm_on_ff;
   logic          tick;

   assign tick = (step_ff == 20'(RAMP_STEP_CYC - 1));

   always_ff @(posedge clock_i) begin
      if (sys_rst_i || !pif.run || tick) begin
         step_ff <= 20'h0;
      end else begin
         step_ff <= step_ff + 20'h1;
      end
   end

   // one step per tick bounds the slew: a full ramp spans the ramp time
   always_ff @(posedge clock_i) begin
      if (sys_rst_i || !pif.run) begin
         duty_ff <= '0;
      end else if (tick) begin
         if (pif.limit && duty_ff != '0) begin
            duty_ff <= duty_ff - DW'(1);
         end else if (pif.above && duty_ff != '0) begin
            duty_ff <= duty_ff - DW'(1);
         end else if (pif.below && !pif.limit && duty_ff != DUTY_MAX) begin
            duty_ff <= duty_ff + DW'(1);
         end
      end
   end

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         cnt_ff    <= '0;
         pwm_on_ff <= 1'b0;
      end else begin
         cnt_ff    <= cnt_ff + DW'(1);
         // full code means no off time at all
         pwm_on_ff <= pif.run && ((duty_ff == DUTY_MAX) || (cnt_ff < duty_ff));
      end
   end

   assign pif.pwm_on = pwm_on_ff;
   assign pif.duty   = duty_ff;
endmodule : hbf_pwm
`default_nettype wire

// [rtl/hbf_top.sv]
// Design decisions made here: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module hbf_top #(
   parameter int SUST_FAULT_CYC   = hbf_pkg::SUST_FAULT_CYC,
   parameter int OC_DEGLITCH_CYC  = hbf_pkg::OC_DEGLITCH_CYC,
   parameter int RAMP_STEP_CYC    = hbf_pkg::RAMP_STEP_CYC
) (
   input  wire logic                      clock_i,        // 20 MHz system clock
   input  wire logic                      sys_rst_i,      // sync reset, active high
   input  wire logic [hbf_pkg::ADDR_W-1:0] s_axi_awaddr,  // write address
   input  wire logic                      s_axi_awvalid,  // write address valid
   output logic                           s_axi_awready,  // write address ready
   input  wire logic [31:0]               s_axi_wdata,    // write data
   input  wire logic [3:0]                s_axi_wstrb,    // write byte strobes
   input  wire logic                      s_axi_wvalid,   // write data valid
   output logic                           s_axi_wready,   // write data ready
   output logic [1:0]                     s_axi_bresp,    // write response
   output logic                           s_axi_bvalid,   // write response valid
   input  wire logic                      s_axi_bready,   // write response ready
   input  wire logic [hbf_pkg::ADDR_W-1:0] s_axi_araddr,  // read address
   input  wire logic                      s_axi_arvalid,  // read address valid
   output logic                           s_axi_arready,  // read address ready
   output logic [31:0]                    s_axi_rdata,    // read data
   output logic [1:0]                     s_axi_rresp,    // read response
   output logic                           s_axi_rvalid,   // read data valid
   input  wire logic                      s_axi_rready,   // read data ready
   input  wire logic                      current_sense_i, // sense above 200 mV
   input  wire logic                      oc_hs_i,        // high-side fet limiting
   input  wire logic                      oc_ls_i,        // low-side fet limiting
   input  wire logic                      thermal_shutdown_i, // die too hot
   input  wire logic                      undervolt_i,    // supply below lockout
   input  wire logic                      avg_below_i,    // averaged out / 4 < target
   input  wire logic                      avg_above_i,    // averaged out / 4 > target
   output logic                           hs_a_o,         // half-bridge a high fet
   output logic                           ls_a_o,         // half-bridge a low fet
   output logic                           hs_b_o,         // half-bridge b high fet
   output logic                           ls_b_o,         // half-bridge b low fet
   output logic                           fault_out_low_o, // fault, active low
   output logic                           sleep_o,        // internals powered down
   output logic [12:0]                    target_mv_o,    // commanded motor mV
   output logic                           code_reserved_o // code has no voltage
);
   localparam int NSYNC = 5;

   // pin synchronisers
   logic [NSYNC-1:0] pin_raw;
   logic [NSYNC-1:0] sync1_ff;
   logic [NSYNC-1:0] sync2_ff;
   assign pin_raw = {avg_below_i, oc_hs_i, oc_ls_i, thermal_shutdown_i, undervolt_i};

   genvar gi;
   generate
      for (gi = 0; gi < NSYNC; gi++) begin : g_sync
         always_ff @(posedge clock_i) begin
            if (sys_rst_i) begin
               sync1_ff[gi] <= 1'b0;
               sync2_ff[gi] <= 1'b0;
            end else begin
               sync1_ff[gi] <= pin_raw[gi];
               sync2_ff[gi] <= sync1_ff[gi];
            end
         end
      end
   endgenerate

   logic sense1_ff, sense2_ff, above1_ff, above2_ff;
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         sense1_ff <= 1'b0;
         sense2_ff <= 1'b0;
         above1_ff <= 1'b0;
         above2_ff <= 1'b0;
      end else begin
         sense1_ff <= current_sense_i;
         sense2_ff <= sense1_ff;
         above1_ff <= avg_above_i;
         above2_ff <= above1_ff;
      end
   end

   logic below_s, oc_hs_s, oc_ls_s, ot_s, uv_s;
   assign {below_s, oc_hs_s, oc_ls_s, ot_s, uv_s} = sync2_ff;

   // registers
   logic [7:0] ctrl_ff;
   logic       sust_ff, oc_ff, ot_ff, uv_ff;
   logic       in_a, in_b;
   logic [5:0] code;
   assign in_a = ctrl_ff[hbf_pkg::CTRL_IN_A_BIT];
   assign in_b = ctrl_ff[hbf_pkg::CTRL_IN_B_BIT];
   assign code = ctrl_ff[hbf_pkg::CTRL_CODE_LSB +: hbf_pkg::CODE_W];

   // bus write: address and data are taken together in one cycle
   logic       wr_go, rd_go, bvalid_ff, rvalid_ff;
   logic [1:0] bresp_ff, rresp_ff;
   logic [31:0] rdata_ff;
   logic [1:0] widx, ridx;
   logic       wr_ctrl, wr_fault, clr_req, mode_clr;

   assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !bvalid_ff;
   assign s_axi_wready  = s_axi_awready;
   assign wr_go         = s_axi_awready;
   assign widx          = s_axi_awaddr[3:2];
   assign wr_ctrl  = wr_go && widx == hbf_pkg::CTRL_IDX && s_axi_wstrb[0];
   assign wr_fault = wr_go && widx == hbf_pkg::FAULT_IDX && s_axi_wstrb[0];
   assign clr_req  = wr_fault && s_axi_wdata[hbf_pkg::FLT_CLEAR_BIT];
   // writing 00 or 11 to the inputs drops a sustained limit fault
   assign mode_clr = wr_ctrl && (s_axi_wdata[hbf_pkg::CTRL_IN_A_BIT]
                                 == s_axi_wdata[hbf_pkg::CTRL_IN_B_BIT]);

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         ctrl_ff <= hbf_pkg::CTRL_RST;
      end else if (wr_ctrl) begin
         ctrl_ff <= s_axi_wdata[7:0];
      end
   end

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         bvalid_ff <= 1'b0;
         bresp_ff  <= hbf_pkg::RESP_OKAY;
      end else if (wr_go) begin
         bvalid_ff <= 1'b1;
         bresp_ff  <= (widx == hbf_pkg::CTRL_IDX || widx == hbf_pkg::FAULT_IDX) ?
                      hbf_pkg::RESP_OKAY : hbf_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_ff <= 1'b0;
      end
   end

   assign s_axi_arready = !rvalid_ff;
   assign rd_go         = s_axi_arvalid && !rvalid_ff;
   assign ridx          = s_axi_araddr[3:2];

   logic summary;
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         rvalid_ff <= 1'b0;
         rdata_ff  <= 32'h0;
         rresp_ff  <= hbf_pkg::RESP_OKAY;
      end else if (rd_go) begin
         rvalid_ff <= 1'b1;
         rresp_ff  <= hbf_pkg::RESP_OKAY;
         if (ridx == hbf_pkg::CTRL_IDX) begin
            rdata_ff <= {24'h0, ctrl_ff};
         end else if (ridx == hbf_pkg::FAULT_IDX) begin
            // clear bit and the unused bits read back as zero
            rdata_ff <= {27'h0, sust_ff, ot_ff, uv_ff, oc_ff, summary};
         end else begin
            rdata_ff <= 32'h0;
            rresp_ff <= hbf_pkg::RESP_SLVERR;
         end
      end else if (s_axi_rready) begin
         rvalid_ff <= 1'b0;
      end
   end

   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp  = bresp_ff;
   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rdata  = rdata_ff;
   assign s_axi_rresp  = rresp_ff;

   // current limit deglitch, then the long sustained timer
   logic [6:0]  ilim_cnt_ff;
   logic        limit_ff;
   logic [31:0] sust_cnt_ff;
   logic        sust_hit;

   always_ff @(posedge clock_i) begin
      if (sys_rst_i || !sense2_ff) begin
         ilim_cnt_ff <= 7'h00;
         limit_ff    <= 1'b0;
      end else if (ilim_cnt_ff == 7'(hbf_pkg::ILIM_DEGLITCH_CYC)) begin
         limit_ff    <= 1'b1;
      end else begin
         ilim_cnt_ff <= ilim_cnt_ff + 7'h01;
      end
   end

   assign sust_hit = limit_ff && sust_cnt_ff == 32'(SUST_FAULT_CYC - 1);

   always_ff @(posedge clock_i) begin
      if (sys_rst_i || !limit_ff || sust_hit) begin
         sust_cnt_ff <= 32'h0;
      end else begin
         sust_cnt_ff <= sust_cnt_ff + 32'h1;
      end
   end

   // per-side overcurrent deglitch, separate from the current limit path
   logic [7:0] oc_cnt_ff [2];
   logic [1:0] oc_hit;
   logic [1:0] oc_in;
   assign oc_in = {oc_hs_s, oc_ls_s};

   generate
      for (gi = 0; gi < 2; gi++) begin : g_oc
         assign oc_hit[gi] = oc_in[gi] &&
                             oc_cnt_ff[gi] == 8'(OC_DEGLITCH_CYC - 1);
         always_ff @(posedge clock_i) begin
            if (sys_rst_i || !oc_in[gi] || oc_hit[gi]) begin
               oc_cnt_ff[gi] <= 8'h00;
            end else begin
               oc_cnt_ff[gi] <= oc_cnt_ff[gi] + 8'h01;
            end
         end
      end
   endgenerate

   // fault flags: a setting event in the clearing cycle wins
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         sust_ff <= 1'b0;
      end else if (sust_hit) begin
         sust_ff <= 1'b1;
      end else if (clr_req || mode_clr) begin
         sust_ff <= 1'b0;
      end
   end

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         oc_ff <= 1'b0;
      end else if (|oc_hit) begin
         oc_ff <= 1'b1;
      end else if (clr_req) begin
         oc_ff <= 1'b0;
      end
   end

   // these two stay set while the condition lasts, clear bit drops history
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         ot_ff <= 1'b0;
         uv_ff <= 1'b0;
      end else begin
         ot_ff <= ot_s || (ot_ff && !clr_req);
         uv_ff <= uv_s || (uv_ff && !clr_req);
      end
   end

   assign summary = sust_ff || oc_ff || ot_ff || uv_ff;

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         fault_out_low_o <= 1'b1;
      end else begin
         fault_out_low_o <= !summary;
      end
   end

   // operating mode
   logic asleep, drive_ok, run;
   assign asleep   = !in_a && !in_b;
   // sustained limit is not in this term: it never stops the bridge
   assign drive_ok = !asleep && !oc_ff && !ot_s && !uv_s;
   // brake and coast both hold the regulator at zero duty
   assign run      = drive_ok && (in_a != in_b) && !code_reserved_o;

   hbf_pwm_if pif ();
   assign pif.run   = run;
   assign pif.limit = limit_ff;
   assign pif.below = below_s;
   assign pif.above = above2_ff;

   hbf_pwm #(
      .RAMP_STEP_CYC (RAMP_STEP_CYC)
   ) u_pwm (
      .clock_i   (clock_i),
      .sys_rst_i (sys_rst_i),
      .pif       (pif.pwm)
   );

   // bridge drive; off time recirculates through both high fets
   logic [3:0] drv;
   always_comb begin
      drv = 4'h0;
      if (drive_ok) begin
         case ({in_a, in_b})
            2'b10:   drv = pif.pwm_on ? 4'b1001 : 4'b1010;
            2'b01:   drv = pif.pwm_on ? 4'b0110 : 4'b1010;
            2'b11:   drv = 4'b1010;
            default: drv = 4'h0;
         endcase
      end
   end

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         {hs_a_o, ls_a_o, hs_b_o, ls_b_o} <= 4'h0;
         sleep_o <= 1'b1;
      end else begin
         {hs_a_o, ls_a_o, hs_b_o, ls_b_o} <= drv;
         sleep_o <= asleep || uv_s;
      end
   end

   // 4 x vref x (code+1) / 64 in millivolts, truncated
   logic [18:0] mv_full;
   assign mv_full = 19'(4 * hbf_pkg::VREF_MV) * 19'({1'b0, code} + 7'h01);
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         target_mv_o     <= 13'h0;
         code_reserved_o <= 1'b1;
      end else begin
         target_mv_o     <= mv_full[18:6];
         code_reserved_o <= code <= hbf_pkg::CODE_RSVD_MAX;
      end
   end
endmodule : hbf_top
`default_nettype wire

// [test/hbf_checker.sv]
`timescale 1ns/1ps
`default_nettype none
module hbf_checker (
   input wire logic        clock_i,            // clock
   input wire logic        sys_rst_i,          // reset
   input wire logic        s_axi_awvalid,      // aw valid
   input wire logic        s_axi_wvalid,       // w valid
   input wire logic        s_axi_awready,      // aw ready
   input wire logic        s_axi_bvalid,       // b valid
   input wire logic        s_axi_arvalid,      // ar valid
   input wire logic        s_axi_arready,      // ar ready
   input wire logic        s_axi_rvalid,       // r valid
   input wire logic        thermal_shutdown_i, // hot
   input wire logic        undervolt_i,        // low supply
   input wire logic        hs_a_o,             // gate
   input wire logic        ls_a_o,             // gate
   input wire logic        hs_b_o,             // gate
   input wire logic        ls_b_o,             // gate
   input wire logic        fault_out_low_o,    // fault pin
   input wire logic        sleep_o,            // sleep
   input wire logic [12:0] target_mv_o,        // target
   input wire logic        code_reserved_o     // reserved code
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (sys_rst_i);
   logic gates_off;
   assign gates_off = !(hs_a_o | ls_a_o | hs_b_o | ls_b_o);
   // analog inputs pass two sync flops and a register, so allow a few cycles
   AST_RST_SHUTDOWN: assert property ($fell(sys_rst_i) |-> gates_off && sleep_o && fault_out_low_o)
      else $error("not in shutdown after reset");
   AST_OT_OFF: assert property (thermal_shutdown_i [*5] |-> gates_off)
      else $error("bridge on while hot");
   AST_OT_PIN: assert property (thermal_shutdown_i [*6] |-> !fault_out_low_o)
      else $error("fault pin high while hot");
   AST_UV_SLEEP: assert property (undervolt_i [*5] |-> sleep_o && gates_off)
      else $error("active during low supply");
   AST_SLEEP_IDLE: assert property (sleep_o |-> gates_off)
      else $error("gates on in sleep");
   AST_NO_SHOOT: assert property (!(hs_a_o && ls_a_o) && !(hs_b_o && ls_b_o))
      else $error("half bridge shorted");
   AST_RSVD_CODE: assert property (code_reserved_o == (target_mv_o < 13'h1F4))
      else $error("reserved flag and target disagree");
   AST_WR_RESP: assert property (s_axi_awvalid && s_axi_wvalid && s_axi_awready |=> s_axi_bvalid)
      else $error("write response late");
   AST_RD_RESP: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read response late");
   COV_FAULT: cover property (!fault_out_low_o);
   COV_BRAKE: cover property (hs_a_o && hs_b_o);
   COV_WAKE: cover property (sleep_o ##1 !sleep_o);
endmodule : hbf_checker
bind hbf_top hbf_checker u_chk (.clock_i, .sys_rst_i, .s_axi_awvalid, .s_axi_wvalid,
   .s_axi_awready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
   .thermal_shutdown_i, .undervolt_i, .hs_a_o, .ls_a_o, .hs_b_o, .ls_b_o,
   .fault_out_low_o, .sleep_o, .target_mv_o, .code_reserved_o);
`default_nettype wire

// [test/hbf_bridge_model.sv]
`timescale 1ns/1ps
`default_nettype none
module hbf_bridge_model (
   input  wire logic [5:0] req_i,   // sense, oc hs, oc ls, hot, uv, below
   output logic            sense_o, // sense over limit
   output logic            oc_hs_o, // high side limiting
   output logic            oc_ls_o, // low side limiting
   output logic            hot_o,   // die hot
   output logic            uv_o,    // supply low
   output logic            below_o, // average under target
   output logic            above_o  // average over target
);
   // comparators never both idle, so the regulator always has a direction
   assign {sense_o, oc_hs_o, oc_ls_o, hot_o, uv_o, below_o} = req_i;
   assign above_o = !req_i[0];
endmodule : hbf_bridge_model
`default_nettype wire

// [test/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
   typedef struct packed {
      logic [7:0]  ctl;
      logic [3:0]  gt;
      logic [3:0]  msk;
      logic        slp;
      logic [12:0] mv;
      logic        rsv;
   } hbf_row_t;
   localparam logic [3:0] A_CTL = {hbf_pkg::CTRL_IDX, 2'h0};
   localparam logic [3:0] A_FLT = {hbf_pkg::FAULT_IDX, 2'h0};
   logic        clock_i = 1'b0, sys_rst_i = 1'b1;
   logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
   logic [5:0]  req = 6'h01;
   logic        current_sense_i, oc_hs_i, oc_ls_i, thermal_shutdown_i, undervolt_i;
   logic        avg_below_i, avg_above_i, hs_a_o, ls_a_o, hs_b_o, ls_b_o;
   logic        fault_out_low_o, sleep_o, code_reserved_o;
   logic [12:0] target_mv_o;
   int          err_total = 0, samples_checked = 0, c;
   logic [7:0]  clr [2] = '{8'h40, 8'h43};
   // gates packed as hs_a, ls_a, hs_b, ls_b; masked bits follow the pwm
   hbf_row_t    rows [6] = '{
      '{8'h00, 4'h0, 4'hF, 1'b1, 13'h050, 1'b1}, '{8'hFF, 4'hA, 4'hF, 1'b0, 13'h1414, 1'b0},
      '{8'h41, 4'h8, 4'hC, 1'b0, 13'h555, 1'b0}, '{8'h16, 4'hA, 4'hF, 1'b0, 13'h1E1, 1'b1},
      '{8'h19, 4'h8, 4'hC, 1'b0, 13'h232, 1'b0}, '{8'hFE, 4'h2, 4'h3, 1'b0, 13'h1414, 1'b0}};

   hbf_bridge_model u_far (.req_i(req), .sense_o(current_sense_i), .oc_hs_o(oc_hs_i),
      .oc_ls_o(oc_ls_i), .hot_o(thermal_shutdown_i), .uv_o(undervolt_i),
      .below_o(avg_below_i), .above_o(avg_above_i));
   // short counts keep the fault and ramp timers within a brief run
   hbf_top #(.SUST_FAULT_CYC(200), .OC_DEGLITCH_CYC(4), .RAMP_STEP_CYC(4)) dut (
      .clock_i, .sys_rst_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .current_sense_i, .oc_hs_i, .oc_ls_i,
      .thermal_shutdown_i, .undervolt_i, .avg_below_i, .avg_above_i, .hs_a_o, .ls_a_o,
      .hs_b_o, .ls_b_o, .fault_out_low_o, .sleep_o, .target_mv_o, .code_reserved_o);

   always #25 clock_i = ~clock_i;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk

   task automatic close_out;
      $display("checks %0d errors %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : close_out

   task automatic limit(input int k, input int lim);
      if (k >= lim) begin
         err_total++;
         $display("ERROR %0t: wait ran out", $time);
         close_out();
      end
   endtask : limit

   // always lets one edge pass: a ready that does not wait for valid is only
   // meaningful at an edge where our request already stands
   task automatic wt(ref logic s, input logic v, input int lim);
      int k;
      for (k = 0; k < lim; k++) begin
         @(posedge clock_i);
         if (s === v) break;
      end
      limit(k, lim);
   endtask : wt

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      logic aw_pend;
      logic w_pend;
      aw_pend = 1'b1;
      w_pend = 1'b1;
      @(posedge clock_i);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h000000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      // each channel is released on its own ready
      for (int k = 0; k < 50 && (aw_pend || w_pend); k++) begin
         @(posedge clock_i);
         if (aw_pend && s_axi_awready) begin
            s_axi_awvalid <= 1'b0;
            aw_pend = 1'b0;
         end
         if (w_pend && s_axi_wready) begin
            s_axi_wvalid <= 1'b0;
            w_pend = 1'b0;
         end
      end
      limit(int'(aw_pend || w_pend), 1);
      wt(s_axi_bvalid, 1'b1, 50);
      rs = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : wr

   task automatic rdr(input logic [3:0] a);
      @(posedge clock_i);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      wt(s_axi_arready, 1'b1, 50);
      s_axi_arvalid <= 1'b0;
      wt(s_axi_rvalid, 1'b1, 50);
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : rdr

   task automatic cnt;
      c = 0;
      repeat (256) begin
         @(posedge clock_i);
         c += (ls_b_o === 1'b1);
      end
   endtask : cnt

   initial begin
      repeat (8) @(posedge clock_i);
      sys_rst_i <= 1'b0;
      @(posedge clock_i);
      chk({hs_a_o, ls_a_o, hs_b_o, ls_b_o, fault_out_low_o, sleep_o}, 6'h03);
      rdr(A_CTL);
      chk(rd, 32'h0);
      rdr(A_FLT);
      chk(rd, 32'h0);
      rdr(4'h8);
      chk(rs, hbf_pkg::RESP_SLVERR);
      wr(4'hC, 8'hFF);
      chk(rs, hbf_pkg::RESP_SLVERR);
      foreach (rows[i]) begin
         wr(A_CTL, rows[i].ctl);
         repeat (4) @(posedge clock_i);
         chk({hs_a_o, ls_a_o, hs_b_o, ls_b_o} & rows[i].msk, rows[i].gt);
         chk(sleep_o, rows[i].slp);
         chk(target_mv_o, rows[i].mv);
         chk(code_reserved_o, rows[i].rsv);
         rdr(A_CTL);
         chk(rd, {24'h000000, rows[i].ctl});
      end
      wr(A_CTL, 8'h41);
      repeat (1100) @(posedge clock_i);
      cnt();
      chk(c > 200, 1'b1);
      wr(A_CTL, 8'h43);
      wr(A_CTL, 8'h41);
      cnt();
      chk(c < 128, 1'b1);
      req <= 6'h00;
      repeat (1100) @(posedge clock_i);
      cnt();
      chk(c, 0);
      req <= 6'h01;
      repeat (1100) @(posedge clock_i);
      req <= 6'h21;
      repeat (150) @(posedge clock_i);
      req <= 6'h01;
      repeat (2) @(posedge clock_i);
      req <= 6'h21;
      repeat (150) @(posedge clock_i);
      chk(fault_out_low_o, 1'b1);
      repeat (1100) @(posedge clock_i);
      cnt();
      chk(c, 0);
      chk({fault_out_low_o, hs_a_o}, 2'h1);
      rdr(A_FLT);
      chk(rd, 32'h11);
      req <= 6'h01;
      repeat (6) @(posedge clock_i);
      wr(A_FLT, 8'h80);
      rdr(A_FLT);
      chk(rd, 32'h0);
      foreach (clr[j]) begin
         wr(A_CTL, 8'h41);
         req <= 6'h21;
         wt(fault_out_low_o, 1'b0, 400);
         req <= 6'h01;
         repeat (6) @(posedge clock_i);
         wr(A_CTL, clr[j]);
         rdr(A_FLT);
         chk(rd, 32'h0);
      end
      for (int s = 0; s < 2; s++) begin
         wr(A_CTL, 8'h41);
         req <= s ? 6'h09 : 6'h11;
         repeat (12) @(posedge clock_i);
         req <= 6'h01;
         repeat (4) @(posedge clock_i);
         chk({hs_a_o, ls_a_o, hs_b_o, ls_b_o, fault_out_low_o}, 5'h00);
         rdr(A_FLT);
         chk(rd, 32'h03);
         repeat (20) @(posedge clock_i);
         chk({hs_a_o, ls_a_o, hs_b_o, ls_b_o}, 4'h0);
         wr(A_FLT, 8'h80);
         repeat (4) @(posedge clock_i);
         chk(hs_a_o, 1'b1);
      end
      wr(A_CTL, 8'h43);
      for (int i = 0; i < 2; i++) begin
         req <= i ? 6'h03 : 6'h05;
         repeat (8) @(posedge clock_i);
         chk({hs_a_o, ls_a_o, hs_b_o, ls_b_o, fault_out_low_o, sleep_o}, i);
         rdr(A_FLT);
         chk(rd, i ? 32'h05 : 32'h09);
         req <= 6'h01;
         repeat (8) @(posedge clock_i);
         chk({hs_a_o, ls_a_o, hs_b_o, ls_b_o, sleep_o}, 5'h14);
         wr(A_FLT, 8'h80);
      end
      wr(A_CTL, 8'h41);
      req <= 6'h21;
      wt(fault_out_low_o, 1'b0, 400);
      req <= 6'h01;
      sys_rst_i <= 1'b1;
      repeat (3) @(posedge clock_i);
      sys_rst_i <= 1'b0;
      @(posedge clock_i);
      chk({hs_a_o, ls_a_o, hs_b_o, ls_b_o, fault_out_low_o, sleep_o}, 6'h03);
      rdr(A_FLT);
      chk(rd, 32'h0);
      close_out();
   end

   initial begin
      repeat (100000) @(posedge clock_i);
      limit(1, 1);
   end
endmodule : testbench
`default_nettype wire
